// *** core/ufc_consts.vh ***
// constants for the flow-control, output-port and baud-select block
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH
// register byte offsets (apb word aligned)
`define UFC_OFS_MODE_A 8'h00
`define UFC_OFS_MODE_B 8'h04
`define UFC_OFS_CMD_A 8'h08
`define UFC_OFS_CMD_B 8'h0c
`define UFC_OFS_CLKSEL_A 8'h10
`define UFC_OFS_CLKSEL_B 8'h14
`define UFC_OFS_AUX 8'h18
`define UFC_OFS_OPSRC 8'h1c
`define UFC_OFS_SETOP 8'h20
`define UFC_OFS_CLROP 8'h24
`define UFC_OFS_STAT_A 8'h28
`define UFC_OFS_STAT_B 8'h2c
`define UFC_OFS_BRGTOG 8'h30
`define UFC_OFS_TEST 8'h34
`define UFC_OFS_TXDATA_A 8'h38
`define UFC_OFS_TXDATA_B 8'h3c
`define UFC_OFS_RXFILL_A 8'h40
`define UFC_OFS_RXFILL_B 8'h44
// mode register fields
`define UFC_MODE_RX_RTS 7
`define UFC_MODE_TX_EMPTY_CTL 6
`define UFC_MODE_TX_CTS 4
`define UFC_MODE_PAR_HI 3
`define UFC_MODE_PAR_LO 2
`define UFC_PAR_WAKEUP 2'b11
// command codes, low nibble of command write
`define UFC_CMD_RX_EN 4'h1
`define UFC_CMD_RX_DIS 4'h2
`define UFC_CMD_TX_EN 4'h4
`define UFC_CMD_TX_DIS 4'h8
`define UFC_CMD_RX_RST 4'h3
// status bits
`define UFC_ST_TX_READY 0
`define UFC_ST_TX_EMPTY 1
`define UFC_ST_RXEN 2
`define UFC_ST_TXEN 3
`define UFC_ST_RTS 4
// clock select codes
`define UFC_CS_TIMER 4'hd
`define UFC_CS_EXT16 4'he
`define UFC_CS_EXT1 4'hf
// receive buffer depth: full at three, fourth start raises rts
`define UFC_RX_FULL 3'd3
// disable window: 3/16 bit in 16x, one bit in 1x (in sample ticks)
`define UFC_DIS_WIN_16X 5'd3
`define UFC_DIS_WIN_1X 5'd1
`define UFC_BITS_PER_CHAR 4'd10
`endif

// *** core/ufc_top.v ***
// two-channel flow control, output port, baud select and tx disable timing
`timescale 1ns/10ps
`include "ufc_consts.vh"
module ufc_top #(
    parameter RATE_W = 20
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // tick at 16x the bit rate (or bit rate in 1x), per channel
    input wire [1:0] bit_tick,
    // remote side, channel b in bit 1
    input wire [1:0] cts_in_n,
    input wire [1:0] rx_start_seen,
    // output port pins, active as documented levels
    output reg [7:0] out_pins,
    output reg [1:0] tx_busy,
    output reg [1:0] tx_load_pulse,
    // selected rate per channel, zero for timer/external codes
    output reg [RATE_W-1:0] rate_a,
    output reg [RATE_W-1:0] rate_b,
    output reg [1:0] clk_ext16,
    output reg [1:0] clk_ext1,
    output reg [1:0] clk_timer
);

    // state encodings, one-hot
    localparam TX_IDLE = 3'b001;
    localparam TX_START = 3'b010;
    localparam TX_SHIFT = 3'b100;

    reg [7:0] mode_reg [0:1];
    reg [7:0] clksel_reg [0:1];
    reg [7:0] aux_reg;
    reg [7:0] opsrc_reg;
    reg [7:0] output_latch_reg;
    reg rate_test_reg;
    reg test_1x_reg;
    reg [1:0] tx_en_reg;
    reg [1:0] rx_en_reg;
    reg [1:0] hold_full_reg;
    reg [1:0] tx_ready_flag_reg;
    reg [1:0] tx_empty_flag_reg;
    reg [1:0] rts_reg;
    reg [2:0] rx_fill_reg [0:1];
    reg [2:0] tx_state_reg [0:1];
    reg [4:0] tick_cnt_reg [0:1];
    reg [3:0] bit_cnt_reg [0:1];
    reg [4:0] since_load_reg [0:1];
    reg [1:0] abort_reg;

    wire wr_en = psel & penable & pwrite & pready;
    wire rd_en = psel & penable & ~pwrite & pready;

    // alternate/normal rate table
    function [RATE_W-1:0] rate_of;
        input [3:0] code;
        input alt;
        input test;
        reg [31:0] r;
        begin
            case ({test, alt, code})
                6'h00: r = 50;
                6'h10: r = 75;
                6'h20: r = 4800;
                6'h30: r = 7200;
                6'h03: r = 200;
                6'h13: r = 150;
                6'h23: r = 19200;
                6'h33: r = 14400;
                6'h07: r = 1050;
                6'h17: r = 2000;
                6'h27: r = 1050;
                6'h37: r = 2000;
                6'h0a: r = 7200;
                6'h1a: r = 1800;
                6'h2a: r = 57600;
                6'h3a: r = 14400;
                6'h0c: r = 38400;
                6'h1c: r = 19200;
                6'h2c: r = 38400;
                6'h3c: r = 19200;
                default: begin
                    case (code)
                        4'h1: r = test ? 880 : 110;
                        4'h2: r = test ? 1076 : 134;
                        4'h4: r = test ? 28800 : 300;
                        4'h5: r = test ? 57600 : 600;
                        4'h6: r = test ? 115200 : 1200;
                        4'h8: r = test ? 57600 : 2400;
                        4'h9: r = 4800;
                        4'hb: r = 9600;
                        default: r = 0;
                    endcase
                end
            endcase
            // every rate fits 20 bits; the cut to the port width is deliberate
            rate_of = r[RATE_W-1:0];
        end
    endfunction

    // flow pin level for one channel
    function flow_pin;
        input latch_bit;
        input rx_ctl;
        input rts;
        input tx_ctl;
        input tx_done;
        begin
            flow_pin = ~(latch_bit | (rx_ctl & rts) | (tx_ctl & tx_done));
        end
    endfunction

    integer ch;
    // own loop index for the pin process, so each variable has one driver
    integer pn;

    // apb: zero wait state, reads of unmapped or write-only addresses answer slverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `UFC_OFS_MODE_A: prdata <= {24'h00_0000, mode_reg[0]};
                    `UFC_OFS_MODE_B: prdata <= {24'h00_0000, mode_reg[1]};
                    `UFC_OFS_CLKSEL_A: prdata <= {24'h00_0000, clksel_reg[0]};
                    `UFC_OFS_CLKSEL_B: prdata <= {24'h00_0000, clksel_reg[1]};
                    `UFC_OFS_AUX: prdata <= {24'h00_0000, aux_reg};
                    `UFC_OFS_OPSRC: prdata <= {24'h00_0000, opsrc_reg};
                    `UFC_OFS_SETOP: prdata <= {24'h00_0000, output_latch_reg};
                    `UFC_OFS_STAT_A: prdata <= {27'h000_0000, rts_reg[0], tx_en_reg[0], rx_en_reg[0],
                                                tx_empty_flag_reg[0], tx_ready_flag_reg[0]};
                    `UFC_OFS_STAT_B: prdata <= {27'h000_0000, rts_reg[1], tx_en_reg[1], rx_en_reg[1],
                                                tx_empty_flag_reg[1], tx_ready_flag_reg[1]};
                    `UFC_OFS_BRGTOG: prdata <= {31'h0000_0000, ~rate_test_reg};
                    `UFC_OFS_TEST: prdata <= {31'h0000_0000, test_1x_reg};
                    `UFC_OFS_RXFILL_A: prdata <= {29'h0000_0000, rx_fill_reg[0]};
                    `UFC_OFS_RXFILL_B: prdata <= {29'h0000_0000, rx_fill_reg[1]};
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg[0] <= 8'h00;
            mode_reg[1] <= 8'h00;
            clksel_reg[0] <= 8'h00;
            clksel_reg[1] <= 8'h00;
            aux_reg <= 8'h00;
            opsrc_reg <= 8'h00;
            output_latch_reg <= 8'h00;
            rate_test_reg <= 1'b0;
            test_1x_reg <= 1'b0;
        end else begin
            if (rd_en && paddr == `UFC_OFS_BRGTOG)
                rate_test_reg <= ~rate_test_reg;
            if (wr_en) begin
                case (paddr)
                    `UFC_OFS_MODE_A: mode_reg[0] <= pwdata[7:0];
                    `UFC_OFS_MODE_B: mode_reg[1] <= pwdata[7:0];
                    `UFC_OFS_CLKSEL_A: clksel_reg[0] <= pwdata[7:0];
                    `UFC_OFS_CLKSEL_B: clksel_reg[1] <= pwdata[7:0];
                    `UFC_OFS_AUX: aux_reg <= pwdata[7:0];
                    `UFC_OFS_OPSRC: opsrc_reg <= pwdata[7:0];
                    `UFC_OFS_SETOP: output_latch_reg <= output_latch_reg | pwdata[7:0];
                    `UFC_OFS_CLROP: output_latch_reg <= output_latch_reg & ~pwdata[7:0];
                    `UFC_OFS_TEST: test_1x_reg <= pwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // per-channel transmitter, receiver fill and flow control
    // independent channel state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (ch = 0; ch < 2; ch = ch + 1) begin
                tx_state_reg[ch] <= TX_IDLE;
                tick_cnt_reg[ch] <= 5'd0;
                bit_cnt_reg[ch] <= 4'd0;
                since_load_reg[ch] <= 5'd0;
                rx_fill_reg[ch] <= 3'd0;
            end
            tx_en_reg <= 2'b00;
            rx_en_reg <= 2'b00;
            hold_full_reg <= 2'b00;
            tx_ready_flag_reg <= 2'b00;
            tx_empty_flag_reg <= 2'b00;
            rts_reg <= 2'b00;
            abort_reg <= 2'b00;
            tx_busy <= 2'b00;
            tx_load_pulse <= 2'b00;
        end else begin
            for (ch = 0; ch < 2; ch = ch + 1) begin
                tx_load_pulse[ch] <= 1'b0;
                if (bit_tick[ch] && since_load_reg[ch] != 5'h1f)
                    since_load_reg[ch] <= since_load_reg[ch] + 5'd1;
                // command handling
                if (wr_en && paddr == (ch == 0 ? `UFC_OFS_CMD_A : `UFC_OFS_CMD_B)) begin
                    if (pwdata[3:0] == `UFC_CMD_TX_EN) begin
                        tx_en_reg[ch] <= 1'b1;
                        tx_empty_flag_reg[ch] <= 1'b1;
                        tx_ready_flag_reg[ch] <= ~hold_full_reg[ch];
                    end
                    if (pwdata[3:0] == `UFC_CMD_TX_DIS) begin
                        tx_en_reg[ch] <= 1'b0;
                        if (hold_full_reg[ch] && (since_load_reg[ch] <
                            ((test_1x_reg | clksel_reg[ch][3:0] == `UFC_CS_EXT1) ?
                             `UFC_DIS_WIN_1X : `UFC_DIS_WIN_16X))) begin
                            hold_full_reg[ch] <= 1'b0;
                            abort_reg[ch] <= 1'b1;
                        end
                        if (tx_state_reg[ch] == TX_START && tx_empty_flag_reg[ch])
                            abort_reg[ch] <= 1'b1;
                    end
                    if (mode_reg[ch][`UFC_MODE_PAR_HI:`UFC_MODE_PAR_LO] != `UFC_PAR_WAKEUP) begin
                        if (pwdata[3:0] == `UFC_CMD_RX_DIS)
                            rx_en_reg[ch] <= 1'b0;
                        if (pwdata[3:0] == `UFC_CMD_RX_RST) begin
                            rx_en_reg[ch] <= 1'b0;
                            rx_fill_reg[ch] <= 3'd0;
                            rts_reg[ch] <= 1'b0;
                        end
                    end
                    if (pwdata[3:0] == `UFC_CMD_RX_EN)
                        rx_en_reg[ch] <= 1'b1;
                end
                // holding register load
                if (wr_en && paddr == (ch == 0 ? `UFC_OFS_TXDATA_A : `UFC_OFS_TXDATA_B) && tx_en_reg[ch]) begin
                    hold_full_reg[ch] <= 1'b1;
                    tx_ready_flag_reg[ch] <= 1'b0;
                    since_load_reg[ch] <= 5'd0;
                    abort_reg[ch] <= 1'b0;
                end
                // receive buffer fill; drained by the fill-register write
                if (wr_en && paddr == (ch == 0 ? `UFC_OFS_RXFILL_A : `UFC_OFS_RXFILL_B)) begin
                    // a start bit landing with the clear is still counted
                    rx_fill_reg[ch] <= {2'b00, rx_start_seen[ch] & rx_en_reg[ch]};
                    rts_reg[ch] <= 1'b0;
                end else if (rx_start_seen[ch] && rx_en_reg[ch]) begin
                    if (rx_fill_reg[ch] == `UFC_RX_FULL)
                        rts_reg[ch] <= 1'b1;
                    else
                        rx_fill_reg[ch] <= rx_fill_reg[ch] + 3'd1;
                end
                // transmitter sequencer
                case (tx_state_reg[ch])
                    TX_IDLE: begin
                        tx_busy[ch] <= 1'b0;
                        // cts gate, gate off ignores cts
                        if (hold_full_reg[ch] && tx_en_reg[ch] && bit_tick[ch] &&
                            !(mode_reg[ch][`UFC_MODE_TX_CTS] && cts_in_n[ch]) &&
                            since_load_reg[ch] >= `UFC_DIS_WIN_16X) begin
                            tx_state_reg[ch] <= TX_START;
                            tick_cnt_reg[ch] <= 5'd0;
                            tx_busy[ch] <= 1'b1;
                        end
                    end
                    TX_START: begin
                        if (abort_reg[ch]) begin
                            // dropped char must not go out on the next enable
                            hold_full_reg[ch] <= 1'b0;
                            tx_state_reg[ch] <= TX_IDLE;
                            tx_empty_flag_reg[ch] <= 1'b1;
                        end else if (bit_tick[ch]) begin
                            tick_cnt_reg[ch] <= tick_cnt_reg[ch] + 5'd1;
                            // transfer in start bit, ready at its end
                            if (tick_cnt_reg[ch] == 5'd15 || test_1x_reg ||
                                clksel_reg[ch][3:0] == `UFC_CS_EXT1) begin
                                hold_full_reg[ch] <= 1'b0;
                                tx_load_pulse[ch] <= 1'b1;
                                tx_ready_flag_reg[ch] <= 1'b1;
                                // empty stays up through the start bit so an underrun drop is seen
                                tx_empty_flag_reg[ch] <= 1'b0;
                                tx_state_reg[ch] <= TX_SHIFT;
                                tick_cnt_reg[ch] <= 5'd0;
                                bit_cnt_reg[ch] <= 4'd1;
                            end
                        end
                    end
                    TX_SHIFT: begin
                        if (bit_tick[ch]) begin
                            tick_cnt_reg[ch] <= tick_cnt_reg[ch] + 5'd1;
                            if (tick_cnt_reg[ch] == 5'd15 || test_1x_reg ||
                                clksel_reg[ch][3:0] == `UFC_CS_EXT1) begin
                                tick_cnt_reg[ch] <= 5'd0;
                                bit_cnt_reg[ch] <= bit_cnt_reg[ch] + 4'd1;
                                if (bit_cnt_reg[ch] == `UFC_BITS_PER_CHAR - 4'd1) begin
                                    tx_state_reg[ch] <= TX_IDLE;
                                    if (!hold_full_reg[ch])
                                        tx_empty_flag_reg[ch] <= 1'b1;
                                end
                            end
                        end
                    end
                    default: tx_state_reg[ch] <= TX_IDLE;
                endcase
            end
        end
    end

    // output pins and rate decode, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pins <= 8'hff;
            rate_a <= {RATE_W{1'b0}};
            rate_b <= {RATE_W{1'b0}};
            clk_ext16 <= 2'b00;
            clk_ext1 <= 2'b00;
            clk_timer <= 2'b00;
        end else begin
            // flow pins as nor with latch
            out_pins[0] <= flow_pin(output_latch_reg[0], mode_reg[0][`UFC_MODE_RX_RTS], rts_reg[0],
                                    mode_reg[0][`UFC_MODE_TX_EMPTY_CTL], tx_empty_flag_reg[0]);
            out_pins[1] <= flow_pin(output_latch_reg[1], mode_reg[1][`UFC_MODE_RX_RTS], rts_reg[1],
                                    mode_reg[1][`UFC_MODE_TX_EMPTY_CTL], tx_empty_flag_reg[1]);
            // source select, inverted latch; test shows nodes
            for (pn = 2; pn < 8; pn = pn + 1)
                out_pins[pn] <= test_1x_reg ? tx_busy[pn & 1] :
                                opsrc_reg[pn] ? ~tx_ready_flag_reg[pn & 1] : ~output_latch_reg[pn];
            rate_a <= rate_of(clksel_reg[0][3:0], aux_reg[7], rate_test_reg);
            rate_b <= rate_of(clksel_reg[1][3:0], aux_reg[7], rate_test_reg);
            for (pn = 0; pn < 2; pn = pn + 1) begin
                clk_timer[pn] <= clksel_reg[pn][3:0] == `UFC_CS_TIMER;
                clk_ext16[pn] <= clksel_reg[pn][3:0] == `UFC_CS_EXT16 && !test_1x_reg;
                clk_ext1[pn] <= clksel_reg[pn][3:0] == `UFC_CS_EXT1 ||
                                (test_1x_reg && clksel_reg[pn][3:0] == `UFC_CS_EXT16);
            end
        end
    end

endmodule // ufc_top

// *** tb/ufc_chk.sv ***
// port-level assertions for the flow-control and baud-select block
`timescale 1ns/10ps
`include "ufc_consts.vh"
module ufc_chk #(
    parameter RATE_W = 20
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // transmit and pins
    input wire [1:0] tx_busy,
    input wire [1:0] tx_load_pulse,
    input wire [7:0] out_pins,
    // baud select
    input wire [RATE_W-1:0] rate_a,
    input wire [RATE_W-1:0] rate_b,
    input wire [1:0] clk_ext16,
    input wire [1:0] clk_ext1,
    input wire [1:0] clk_timer
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr_done(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    a_pready_next: assert property (s_setup |=> pready) else $error("no pready after setup");
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_hold: assert property (!$stable(prdata) |-> pready) else $error("prdata moved outside a transfer");
    a_set_pin_low: assert property (s_wr_done(`UFC_OFS_SETOP) ##0 pwdata[0] |=> ##[0:1] !out_pins[0])
        else $error("flow pin a not low after latch set");
    a_rate_a_zero: assert property ((clk_timer[0] || clk_ext16[0] || clk_ext1[0]) |-> rate_a == 0)
        else $error("rate a nonzero on special code");
    a_rate_b_zero: assert property ((clk_timer[1] || clk_ext16[1] || clk_ext1[1]) |-> rate_b == 0)
        else $error("rate b nonzero on special code");
    a_clk_kind_one: assert property ($onehot0({clk_timer[0], clk_ext16[0], clk_ext1[0]}))
        else $error("two clock kinds at once");
    a_load_busy_a: assert property (tx_load_pulse[0] |-> ##[0:1] tx_busy[0])
        else $error("load a outside a character");
    a_load_busy_b: assert property (tx_load_pulse[1] |-> ##[0:1] tx_busy[1])
        else $error("load b outside a character");
endmodule // ufc_chk
bind ufc_top ufc_chk #(.RATE_W(RATE_W)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_busy(tx_busy), .tx_load_pulse(tx_load_pulse), .out_pins(out_pins), .rate_a(rate_a), .rate_b(rate_b),
    .clk_ext16(clk_ext16), .clk_ext1(clk_ext1), .clk_timer(clk_timer));

// *** tb/ufc_remote.sv ***
// remote serial party: sample ticks, clear-to-send and start-bit pulses
`timescale 1ns/10ps
module ufc_remote (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // bench controls
    input wire [1:0] cts_hold,
    input wire [1:0] start_req,
    // lines toward the block
    output reg [1:0] bit_tick,
    output reg [1:0] cts_in_n,
    output reg [1:0] rx_start_seen
);
    reg [1:0] div_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
            bit_tick <= 2'h0;
            cts_in_n <= 2'h0;
            rx_start_seen <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
            // channels tick out of step so they never align
            bit_tick <= {div_reg == 2'h2, div_reg == 2'h0};
            cts_in_n <= cts_hold;
            rx_start_seen <= start_req;
        end
    end
endmodule // ufc_remote

// *** tb/test_uart_flow_ctrl_baud_outport.sv ***
// self-checking bench for ufc_top
`timescale 1ns/10ps
`include "ufc_consts.vh"
module test_uart_flow_ctrl_baud_outport;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [1:0] cts_hold = 2'h0;
    reg [1:0] start_req = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [1:0] bit_tick, cts_in_n, rx_start_seen, tx_busy, tx_load_pulse, clk_ext16, clk_ext1, clk_timer;
    wire [7:0] out_pins;
    wire [19:0] rate_a, rate_b;
    logic [31:0] rdat;
    logic rerr;
    int fails = 0;
    int compares = 0;
    int rt[4][13] = '{'{50, 110, 134, 200, 300, 600, 1200, 1050, 2400, 4800, 7200, 9600, 38400},
        '{75, 110, 134, 150, 300, 600, 1200, 2000, 2400, 4800, 1800, 9600, 19200},
        '{4800, 880, 1076, 19200, 28800, 57600, 115200, 1050, 57600, 4800, 57600, 9600, 38400},
        '{7200, 880, 1076, 14400, 28800, 57600, 115200, 2000, 57600, 4800, 14400, 9600, 19200}};
    always #20 pclk = ~pclk;
    ufc_top #(.RATE_W(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick),
        .cts_in_n(cts_in_n), .rx_start_seen(rx_start_seen), .out_pins(out_pins), .tx_busy(tx_busy),
        .tx_load_pulse(tx_load_pulse), .rate_a(rate_a), .rate_b(rate_b), .clk_ext16(clk_ext16),
        .clk_ext1(clk_ext1), .clk_timer(clk_timer));
    ufc_remote remote_u (.pclk(pclk), .presetn(presetn), .cts_hold(cts_hold), .start_req(start_req),
        .bit_tick(bit_tick), .cts_in_n(cts_in_n), .rx_start_seen(rx_start_seen));
    function automatic logic [31:0] exp_rate(input logic [3:0] code, input int set, input int alt);
        return (code > 12) ? 32'h0 : rt[alt * 2 + set][code];
    endfunction
    task print_verdict;
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer, then two idle cycles so registered outputs settle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            print_verdict;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task watch(input int lim, output logic [1:0] seen);
        seen = 2'b00;
        repeat (lim) begin
            @(posedge pclk);
            seen = seen | tx_busy;
        end
    endtask
    initial begin
        logic [7:0] lat, m;
        logic [3:0] ca, cb;
        logic [1:0] s;
        void'($urandom(10));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(out_pins, 8'hff);
        lat = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'hff : $urandom;
            apb(1, `UFC_OFS_SETOP, {24'h0, m});
            lat = lat | m;
            apb(0, `UFC_OFS_SETOP, 0);
            chk(rdat, {24'h0, lat});
            chk(out_pins, {24'h0, ~lat});
            m = $urandom;
            apb(1, `UFC_OFS_CLROP, {24'h0, m});
            lat = lat & ~m;
            chk(out_pins, {24'h0, ~lat});
        end
        apb(1, `UFC_OFS_TEST, 1);
        chk(out_pins[7:2], 6'h00);
        apb(1, `UFC_OFS_TEST, 0);
        apb(1, `UFC_OFS_SETOP, 8'hfc);
        lat = lat | 8'hfc;
        apb(1, `UFC_OFS_OPSRC, 8'hfc);
        chk(out_pins[7:2], 6'h3f);
        apb(1, `UFC_OFS_OPSRC, 0);
        apb(1, `UFC_OFS_CLROP, 3);
        lat[1:0] = 2'b00;
        apb(1, `UFC_OFS_MODE_A, 32'h80);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_RX_EN);
        for (int k = 1; k <= 4; k++) begin
            start_req <= 2'b01;
            @(posedge pclk);
            start_req <= 2'b00;
            repeat (3) @(posedge pclk);
            apb(0, `UFC_OFS_STAT_A, 0);
            chk(rdat[`UFC_ST_RTS], k == 4);
            chk(out_pins[1:0], {~lat[1], k != 4});
        end
        apb(1, `UFC_OFS_MODE_A, 0);
        chk(out_pins[0], 1);
        apb(1, `UFC_OFS_RXFILL_A, 0);
        apb(1, `UFC_OFS_MODE_A, 32'h0c);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_RX_DIS);
        apb(0, `UFC_OFS_STAT_A, 0);
        chk(rdat[`UFC_ST_RXEN], 1);
        apb(1, `UFC_OFS_MODE_A, 32'h04);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_RX_RST);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_RX_EN);
        apb(0, `UFC_OFS_MODE_A, 0);
        chk(rdat, 32'h04);
        apb(0, 8'hfc, 0);
        chk({rerr, rdat[30:0]}, 32'h80000000);
        for (int alt = 0; alt < 2; alt++) begin
            for (int st = 0; st < 2; st++) begin
                apb(1, `UFC_OFS_AUX, st << 7);
                for (int c = 0; c < 16; c++) begin
                    ca = c;
                    cb = $urandom;
                    apb(1, `UFC_OFS_CLKSEL_A, ca);
                    apb(1, `UFC_OFS_CLKSEL_B, cb);
                    chk(rate_a, exp_rate(ca, st, alt));
                    chk(rate_b, exp_rate(cb, st, alt));
                    chk({clk_timer[0], clk_ext16[0], clk_ext1[0]}, {ca == 13, ca == 14, ca == 15});
                end
            end
            apb(0, `UFC_OFS_BRGTOG, 0);
        end
        apb(1, `UFC_OFS_CLKSEL_A, 0);
        apb(1, `UFC_OFS_CLKSEL_B, 0);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_TX_EN);
        apb(0, `UFC_OFS_STAT_A, 0);
        chk(rdat[`UFC_ST_TX_EMPTY], 1);
        apb(1, `UFC_OFS_TXDATA_A, $urandom & 8'hff);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_TX_DIS);
        watch(700, s);
        chk(s, 2'b00);
        apb(0, `UFC_OFS_STAT_A, 0);
        chk(rdat[`UFC_ST_TX_EMPTY], 1);
        cts_hold <= 2'b11;
        apb(1, `UFC_OFS_MODE_A, 32'h10);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_TX_EN);
        apb(1, `UFC_OFS_CMD_B, `UFC_CMD_TX_EN);
        apb(1, `UFC_OFS_TXDATA_A, $urandom & 8'hff);
        apb(1, `UFC_OFS_TXDATA_B, $urandom & 8'hff);
        watch(200, s);
        chk(s, 2'b10);
        cts_hold <= 2'b00;
        watch(300, s);
        chk(s[0], 1);
        apb(0, `UFC_OFS_STAT_A, 0);
        chk(rdat[`UFC_ST_TX_READY], 1);
        apb(1, `UFC_OFS_CMD_A, `UFC_CMD_TX_DIS);
        watch(800, s);
        apb(1, `UFC_OFS_MODE_B, 32'h40);
        chk(out_pins[1], 0);
        print_verdict;
    end
endmodule // test_uart_flow_ctrl_baud_outport
